// [hw/tbi_pkg.sv]
// Constants, register map and types for the time base interrupt timer.
package tbi_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] TBI_OFS_TB0  = 8'h00;
    localparam logic [7:0] TBI_OFS_TB1  = 8'h04;
    localparam logic [7:0] TBI_OFS_PSC  = 8'h08;
    localparam logic [7:0] TBI_OFS_IRQ  = 8'h0c;
    // ==========================================================
    // Field positions
    localparam int TBI_BIT_RUN  = 7;
    localparam int TBI_SEL_HI   = 2;
    localparam int TBI_SRC_HI   = 1;
    localparam int TBI_BIT_EMI  = 0;
    localparam int TBI_BIT_EN0  = 1;
    localparam int TBI_BIT_EN1  = 2;
    localparam int TBI_BIT_FL0  = 3;
    localparam int TBI_BIT_FL1  = 4;
    // ==========================================================
    // Reset values
    localparam logic [7:0] TBI_RST_CTRL = 8'h00;
    localparam logic [1:0] TBI_RST_SRC  = 2'h0;
    // ==========================================================
    // Prescaler source codes and timing
    localparam logic [1:0] TBI_SRC_SYS  = 2'h0;
    localparam logic [1:0] TBI_SRC_DIV4 = 2'h1;
    localparam logic [1:0] TBI_DIV4_TOP = 2'h3;
    localparam int TBI_EXP_BASE = 8;
    localparam int TBI_CNT_W    = 15;
    localparam int TBI_NUM_CH   = 2;
    // ==========================================================
    // Bus slave states
    typedef enum logic [3:0] {
        TBI_ST_IDLE  = 4'h1,
        TBI_ST_WR    = 4'h2,
        TBI_ST_RD    = 4'h4,
        TBI_ST_RDOUT = 4'h8
    } tbi_bus_e;
endpackage

// [hw/tbi_top.sv]
// Two-channel time base generator with interrupt request logic.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// - Bit 7 run control stops or runs channel
// - Channel 0 period 2^8..2^15 by code
// - Channel 1 period same encoding, own field
// - Bits 6 to 3 read zero, ignore writes
// - Source: system, system/4, or sub clock
// - Period elapsed sets channel request flag
// - Take needs enables, free stack; clears flag/global
// - Separate prescaler register selects source, resets zero
// - Rising request flag produces a wake-up
// - Wake-up ignores all interrupt enable bits
// - Flag stays until serviced or cleared
// - Disabled source is never serviced, stays pending
// - Entry pushes only program counter
// - Interrupt return sets global enable; plain doesn't
module tbi_top
    import tbi_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP,
    // Sub clock pin
    input  wire logic        SUB_CLK,
    // CPU interrupt side
    input  wire logic        STACK_FULL,
    input  wire logic        RETURN_FROM_INTERRUPT_EXEC,
    input  wire logic        RET_EXEC,
    output logic [1:0]       TB_VECTOR,
    output logic             PC_PUSH,
    output logic             GLOBAL_IRQ_EN,
    output logic             WAKE
);

    // ==========================================================
    // Period decode
    function automatic logic [TBI_CNT_W-1:0] last_count(
        input logic [2:0] sel);
        last_count = TBI_CNT_W'((32'd1 << (TBI_EXP_BASE + 32'(sel)))
                     - 32'd1);
    endfunction

    tbi_bus_e    state;
    tbi_bus_e    next_state;
    logic [7:0]  addr;
    logic [7:0]  next_addr;
    logic        next_ready;
    logic [31:0] next_rdata;
    logic [31:0] rd_data;
    logic        accept;
    logic        wr;

    logic [1:0]       run;
    logic [1:0]       next_run;
    logic [1:0][2:0]  sel;
    logic [1:0][2:0]  next_sel;
    logic [1:0]       src;
    logic [1:0]       next_src;
    logic [1:0]       en;
    logic [1:0]       next_en;
    logic [1:0]       flag;
    logic [1:0]       next_flag;
    logic             next_emi;
    logic [1:0]       take;
    logic [1:0]       expire;

    logic [1:0] div;
    logic [1:0] next_div;
    logic       sub_s1;
    logic       sub_s2;
    logic       sub_s3;
    logic       psc_tick;

    // ==========================================================
    // Bus slave
    // Reads take one wait state so that a read right after a
    // write always returns the value just written.
    assign accept = HSEL && HTRANS[1] && HREADY
                    && (state != TBI_ST_RD);
    assign wr = (state == TBI_ST_WR);

    always_comb begin
        rd_data = 32'h0;
        if (addr == TBI_OFS_TB0) begin
            rd_data = {24'h0, run[0], 4'h0, sel[0]};
        end else if (addr == TBI_OFS_TB1) begin
            rd_data = {24'h0, run[1], 4'h0, sel[1]};
        end else if (addr == TBI_OFS_PSC) begin
            rd_data = {30'h0, src};
        end else if (addr == TBI_OFS_IRQ) begin
            rd_data = {27'h0, flag, en, GLOBAL_IRQ_EN};
        end
    end

    always_comb begin
        next_state = state;
        next_addr  = addr;
        next_ready = HREADYOUT;
        next_rdata = HRDATA;
        case (state)
            TBI_ST_RD: begin
                next_rdata = rd_data;
                next_ready = 1'b1;
                next_state = TBI_ST_RDOUT;
            end
            default: begin
                next_ready = 1'b1;
                next_state = TBI_ST_IDLE;
                if (accept) begin
                    next_addr = HADDR[7:0];
                    if (HWRITE) begin
                        next_state = TBI_ST_WR;
                    end else begin
                        next_state = TBI_ST_RD;
                        next_ready = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state     <= TBI_ST_IDLE;
            addr      <= 8'h00;
            HREADYOUT <= 1'b1;
            HRDATA    <= 32'h0;
            HRESP     <= 1'b0;
        end else begin
            state     <= next_state;
            addr      <= next_addr;
            HREADYOUT <= next_ready;
            HRDATA    <= next_rdata;
            HRESP     <= 1'b0;
        end
    end

    // ==========================================================
    // Control registers
    always_comb begin
        next_run = run;
        next_sel = sel;
        next_src = src;
        next_en  = en;
        if (wr && addr == TBI_OFS_TB0) begin
            next_run[0] = HWDATA[TBI_BIT_RUN];
            next_sel[0] = HWDATA[TBI_SEL_HI:0];
        end else if (wr && addr == TBI_OFS_TB1) begin
            next_run[1] = HWDATA[TBI_BIT_RUN];
            next_sel[1] = HWDATA[TBI_SEL_HI:0];
        end else if (wr && addr == TBI_OFS_PSC) begin
            next_src = HWDATA[TBI_SRC_HI:0];
        end else if (wr && addr == TBI_OFS_IRQ) begin
            next_en = HWDATA[TBI_BIT_EN1:TBI_BIT_EN0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            run <= {TBI_RST_CTRL[TBI_BIT_RUN], TBI_RST_CTRL[TBI_BIT_RUN]};
            sel <= {TBI_RST_CTRL[2:0], TBI_RST_CTRL[2:0]};
            src <= TBI_RST_SRC;
            en  <= 2'h0;
        end else begin
            run <= next_run;
            sel <= next_sel;
            src <= next_src;
            en  <= next_en;
        end
    end

    // ==========================================================
    // Prescaler clock enable
    // The sub clock must run below half the reference rate, or
    // edges are lost in the synchroniser.
    always_comb begin
        next_div = div + 2'h1;
        if (src == TBI_SRC_SYS) begin
            psc_tick = 1'b1;
        end else if (src == TBI_SRC_DIV4) begin
            psc_tick = (div == TBI_DIV4_TOP);
        end else begin
            psc_tick = sub_s2 && !sub_s3;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            div    <= 2'h0;
            sub_s1 <= 1'b0;
            sub_s2 <= 1'b0;
            sub_s3 <= 1'b0;
        end else begin
            div    <= next_div;
            sub_s1 <= SUB_CLK;
            sub_s2 <= sub_s1;
            sub_s3 <= sub_s2;
        end
    end

    // ==========================================================
    // Period counters
    for (genvar i = 0; i < TBI_NUM_CH; i++) begin : g_ch
        logic [TBI_CNT_W-1:0] cnt;
        logic [TBI_CNT_W-1:0] next_cnt;
        logic                 hit;

        always_comb begin
            next_cnt = cnt;
            hit      = 1'b0;
            if (!run[i]) begin
                next_cnt = '0;
            end else if (psc_tick) begin
                if (cnt >= last_count(sel[i])) begin
                    next_cnt = '0;
                    hit      = 1'b1;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
        end

        assign expire[i] = hit;

        always_ff @(posedge REF_CLK) begin
            if (RST) begin
                cnt <= '0;
            end else begin
                cnt <= next_cnt;
            end
        end
    end

    // ==========================================================
    // Request flags, service and return
    // Hardware setting a flag wins over any clear in that cycle.
    always_comb begin
        take[0] = GLOBAL_IRQ_EN && en[0] && flag[0]
                  && !STACK_FULL;
        take[1] = GLOBAL_IRQ_EN && en[1] && flag[1]
                  && !STACK_FULL && !take[0];
        next_flag = flag;
        next_emi  = GLOBAL_IRQ_EN;
        if (wr && addr == TBI_OFS_IRQ) begin
            next_flag = HWDATA[TBI_BIT_FL1:TBI_BIT_FL0];
            next_emi  = HWDATA[TBI_BIT_EMI];
        end
        if (RETURN_FROM_INTERRUPT_EXEC) begin
            next_emi = 1'b1;
        end
        if (take != 2'h0) begin
            next_emi = 1'b0;
        end
        next_flag = (next_flag & ~take) | expire;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            flag          <= 2'h0;
            GLOBAL_IRQ_EN <= 1'b0;
            TB_VECTOR     <= 2'h0;
            PC_PUSH       <= 1'b0;
            WAKE          <= 1'b0;
        end else begin
            flag          <= next_flag;
            GLOBAL_IRQ_EN <= next_emi;
            TB_VECTOR     <= take;
            PC_PUSH       <= (take != 2'h0);
            WAKE          <= |(next_flag & ~flag);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    property p_stop_clear;
        !run[0] |=> (g_ch[0].cnt == '0);
    endproperty
    a_stop_clear: assert property (p_stop_clear)
        else $error("stopped counter not held clear");

    property p_period;
        (src == TBI_SRC_SYS && run[0] && sel[0] == 3'h0
         && g_ch[0].cnt == 15'd255) |=> flag[0];
    endproperty
    a_period: assert property (p_period)
        else $error("flag not set after 256 ticks");

    property p_rsvd;
        (state == TBI_ST_RD && addr == TBI_OFS_TB1)
        |=> (HRDATA[6:3] == 4'h0);
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("unimplemented bits read nonzero");

    property p_take;
        TB_VECTOR[0] |-> $past(GLOBAL_IRQ_EN && en[0] && flag[0]
                               && !STACK_FULL);
    endproperty
    a_take: assert property (p_take)
        else $error("vector taken without its conditions");

    property p_emi_clr;
        (TB_VECTOR != 2'h0) |-> !GLOBAL_IRQ_EN && PC_PUSH;
    endproperty
    a_emi_clr: assert property (p_emi_clr)
        else $error("global enable left set on entry");

    property p_no_en;
        !en[1] |=> !TB_VECTOR[1];
    endproperty
    a_no_en: assert property (p_no_en)
        else $error("disabled source serviced");

    property p_wake;
        $rose(flag[0]) |-> WAKE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("rising flag gave no wake-up");

    property p_hold;
        (flag[1] && !take[1] && !wr) |=> flag[1];
    endproperty
    a_hold: assert property (p_hold)
        else $error("request flag lost");

    property p_return_from_interrupt;
        (RETURN_FROM_INTERRUPT_EXEC && take == 2'h0) |=> GLOBAL_IRQ_EN;
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt)
        else $error("interrupt return left enable clear");

    property p_ret;
        (RET_EXEC && !RETURN_FROM_INTERRUPT_EXEC && !GLOBAL_IRQ_EN && !wr)
        |=> !GLOBAL_IRQ_EN;
    endproperty
    a_ret: assert property (p_ret)
        else $error("plain return set enable");

endmodule

// [testbench/tbi_cpu_model.sv]
// Behavioural CPU side that answers each taken interrupt with a return.
`timescale 1ns/1ps

// ==========================================================
// CPU return model
module tbi_cpu_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Interrupt entry and return control
    input  wire logic       pc_push,
    input  wire logic       use_ret,
    input  wire logic [3:0] resp_dly,
    output logic            return_from_interrupt_exec,
    output logic            ret_exec
);
    int cnt;

    initial begin
        return_from_interrupt_exec = 1'b0;
        ret_exec  = 1'b0;
        cnt       = 0;
    end

    // One service at a time; the handler never nests a call, so the
    // single return level can not be overrun.
    always @(posedge clk) begin
        return_from_interrupt_exec <= 1'b0;
        ret_exec  <= 1'b0;
        if (rst) begin
            cnt <= 0;
        end else if (pc_push === 1'b1) begin
            cnt <= int'(resp_dly) + 2;
        end else if (cnt == 1) begin
            cnt       <= 0;
            return_from_interrupt_exec <= !use_ret;
            ret_exec  <= use_ret;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// [testbench/time_base_interrupt_timer_bench.sv]
// Self-checking bench for the two-channel time base timer.
`timescale 1ns/1ps

module time_base_interrupt_timer_bench;
    import tbi_pkg::*;
    logic        ref_clk    = 1'b0;
    logic        rst        = 1'b1;
    logic        hsel       = 1'b0;
    logic        hwrite     = 1'b0;
    logic        stack_full = 1'b0;
    logic        use_ret    = 1'b0;
    logic [1:0]  htrans     = 2'h0;
    logic [1:0]  sub_cnt    = 2'h0;
    logic [3:0]  dly        = 4'h0;
    logic [31:0] haddr      = 32'h0;
    logic [31:0] hwdata     = 32'h0;
    logic [31:0] rnd        = 32'h7ec6318c;
    logic [31:0] mask [3]   = '{32'h87, 32'h87, 32'h03};
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic        pc_push;
    wire logic        glob;
    wire logic        wake;
    wire logic        return_from_interrupt;
    wire logic        ret;
    wire logic [1:0]  vec;
    wire logic [31:0] hrdata;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc       = 0;
    int wake_cnt  = 0;
    int vec_cnt   = 0;
    int push_cnt  = 0;

    always #50 ref_clk = ~ref_clk;

    tbi_top tbi_top_i (.REF_CLK(ref_clk), .RST(rst), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
        .HRDATA(hrdata), .HRESP(hresp), .SUB_CLK(sub_cnt[1]),
        .STACK_FULL(stack_full), .RETURN_FROM_INTERRUPT_EXEC(return_from_interrupt), .RET_EXEC(ret),
        .TB_VECTOR(vec), .PC_PUSH(pc_push), .GLOBAL_IRQ_EN(glob),
        .WAKE(wake));

    tbi_cpu_model tbi_cpu_model_i (.clk(ref_clk), .rst(rst),
        .pc_push(pc_push), .use_ret(use_ret), .resp_dly(dly),
        .return_from_interrupt_exec(return_from_interrupt), .ret_exec(ret));

    // ==========================================================
    // Event counters, sub clock of four cycles, hang limit
    always @(posedge ref_clk) begin
        cyc     <= cyc + 1;
        sub_cnt <= sub_cnt + 2'h1;
        if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
        if (vec !== 2'h0) vec_cnt <= vec_cnt + 1;
        if (pc_push === 1'b1) push_cnt <= push_cnt + 1;
        if (cyc == 100000) begin
            error_cnt = error_cnt + 1;
            print_verdict;
        end
    end

    // ==========================================================
    // Model and bus tasks
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    function automatic int period(input int src, input int sel);
        return (1 << (8 + sel)) * ((src == 0) ? 1 : 4);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Cycles from run enable to the taken vector, with a margin for the
    // prescaler phase and the sub clock synchroniser.
    task automatic meas(input int ch, input int src, input int sel);
        int n;
        int e;
        int hi;
        e  = period(src, sel);
        hi = e + ((src == 0) ? 4 : (src == 1) ? 6 : 14);
        n  = 0;
        rnd = lfsr(rnd);
        dly <= rnd[3:0];
        wr(TBI_OFS_PSC, 32'(src));
        wr(TBI_OFS_IRQ, 32'h07);
        wr(8'(ch * 4), 32'h80 | 32'(sel));
        while (vec[ch] !== 1'b1 && n < hi + 8) begin
            @(posedge ref_clk);
            n++;
        end
        chk({31'h0, n >= e - 2 && n <= hi}, 32'h1);
        wr(8'(ch * 4), 32'h0);
        settle(24);
        chk({31'h0, glob}, 32'h1);
    endtask

    task print_verdict;
        $display("error_cnt %0d tests_run %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        int i;
        int w;
        int v;
        settle(20);
        rst <= 1'b0;
        settle(1);
        chk({31'h0, glob}, 32'h0);
        for (i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
        for (i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wr(8'(i % 3 * 4), rnd);
            rd(8'(i % 3 * 4), rnd & mask[i % 3]);
        end
        wr(TBI_OFS_TB0, 32'h0);
        wr(TBI_OFS_TB1, 32'h0);
        for (i = 0; i < 8; i++) meas(i % 2, 0, i);
        for (i = 1; i < 4; i++) meas(i % 2, i, 0);
        wr(TBI_OFS_PSC, 32'h0);
        w = wake_cnt;
        v = vec_cnt;
        wr(TBI_OFS_IRQ, 32'h08);
        settle(4);
        chk(32'(wake_cnt), 32'(w + 1));
        wr(TBI_OFS_TB0, 32'h80);
        settle(600);
        wr(TBI_OFS_TB0, 32'h0);
        chk(32'(wake_cnt), 32'(w + 1));
        rd(TBI_OFS_IRQ, 32'h08);
        wr(TBI_OFS_IRQ, 32'h01);
        wr(TBI_OFS_TB0, 32'h80);
        settle(300);
        wr(TBI_OFS_TB0, 32'h0);
        chk(32'(wake_cnt), 32'(w + 2));
        chk(32'(vec_cnt), 32'(v));
        rd(TBI_OFS_IRQ, 32'h09);
        stack_full <= 1'b1;
        use_ret    <= 1'b1;
        wr(TBI_OFS_IRQ, 32'h0b);
        settle(20);
        chk(32'(vec_cnt), 32'(v));
        stack_full <= 1'b0;
        settle(30);
        chk(32'(vec_cnt), 32'(v + 1));
        rd(TBI_OFS_IRQ, 32'h02);
        use_ret <= 1'b0;
        wr(TBI_OFS_IRQ, 32'h0b);
        settle(30);
        rd(TBI_OFS_IRQ, 32'h03);
        chk(32'(push_cnt), 32'(vec_cnt));
        print_verdict;
    end
endmodule
